/* hw/psbst_defs.vh */
/*
 * constants of the pseudo-static ram synchronous burst engine.
 * assumes it is included by bare name from the design files under hw/.
 */
`ifndef PSBST_DEFS_VH
`define PSBST_DEFS_VH

// ==========================================================
// burst configuration
`define PSBST_LATENCY 5
`define PSBST_BURST_LEN 4
`define PSBST_DATA_W 16
`define PSBST_ADDR_W 8

// ==========================================================
// engine states
`define PSBST_ST_IDLE 2'h0
`define PSBST_ST_LAT 2'h1
`define PSBST_ST_DATA 2'h2
`define PSBST_ST_DONE 2'h3

// ==========================================================
// synchroniser bit positions
`define PSBST_SY_BCLK 0
`define PSBST_SY_CS 1
`define PSBST_SY_ADV 2
`define PSBST_SY_WE 3
`define PSBST_SY_OE 4
`define PSBST_SY_UB 5
`define PSBST_SY_LB 6
`define PSBST_SY_W 7

`endif

/* hw/psbst_mem.v */
/*
 * storage array of the burst engine with byte-lane writes and registered read.
 * assumes one clock and that read address is stable a cycle before use.
 */
module psbst_mem #(
    parameter ADDR_W = 8,
    parameter DATA_W = 16
) (
    input wire ref_clk,
    input wire wr_en,
    input wire [1:0] wr_lane,
    input wire [ADDR_W-1:0] wr_addr,
    input wire [DATA_W-1:0] wr_data,
    input wire [ADDR_W-1:0] rd_addr,
    output reg [DATA_W-1:0] rd_data_reg
);
    localparam HALF = DATA_W / 2;
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // ==========================================================
    // array access; no reset so it maps onto ram
    always @(posedge ref_clk) begin
        if (wr_en && wr_lane[0]) begin
            mem[wr_addr][HALF-1:0] <= wr_data[HALF-1:0];
        end
        if (wr_en && wr_lane[1]) begin
            mem[wr_addr][DATA_W-1:HALF] <= wr_data[DATA_W-1:HALF];
        end
        rd_data_reg <= mem[rd_addr];
    end
endmodule

/* hw/psbst_top.v */
/*
 * device side of a pseudo-static ram synchronous burst interface:
 * latency counting, wait signalling, burst read with suspend, burst write,
 * early stop by chip select.
 * assumes every pin is asynchronous to ref_clk and the burst clock runs
 * well below a quarter of ref_clk so each edge is seen once.
 */
`include "psbst_defs.vh"

module psbst_top #(
    parameter LATENCY = `PSBST_LATENCY,
    parameter BURST_LEN = `PSBST_BURST_LEN,
    parameter ADDR_W = `PSBST_ADDR_W,
    parameter DATA_W = `PSBST_DATA_W
) (
    input wire ref_clk,
    input wire nrst,
    input wire burst_clk,
    input wire chip_select_n,
    input wire address_valid_n,
    input wire write_enable_n,
    input wire output_enable_n,
    input wire upper_byte_mask_n,
    input wire lower_byte_mask_n,
    input wire [ADDR_W-1:0] addr,
    input wire [DATA_W-1:0] dq_in,
    output reg [DATA_W-1:0] dq_out_reg,
    output reg dq_oe_reg,
    output reg wait_n_reg,
    output reg wait_oe_reg
);
    localparam CNT_W = $clog2(LATENCY + 1);
    localparam IDX_W = $clog2(BURST_LEN + 1);
    localparam [CNT_W-1:0] LAT_FULL = LATENCY;
    localparam [CNT_W-1:0] LAT_READY = LATENCY - 1;
    localparam [CNT_W-1:0] CNT_ONE = 1;
    localparam [IDX_W-1:0] IDX_LAST = BURST_LEN;
    localparam [IDX_W-1:0] IDX_ONE = 1;
    localparam [ADDR_W-1:0] ADDR_ZERO = 0;
    localparam [DATA_W-1:0] DATA_ZERO = 0;

    // ==========================================================
    // pin synchronisers; stage one feeds stage two only
    reg [`PSBST_SY_W-1:0] sy1_reg;
    reg [`PSBST_SY_W-1:0] sy2_reg;
    reg [`PSBST_SY_W-1:0] sy3_reg;
    reg [ADDR_W-1:0] addr1_reg;
    reg [ADDR_W-1:0] addr2_reg;
    reg [DATA_W-1:0] din1_reg;
    reg [DATA_W-1:0] din2_reg;
    wire [`PSBST_SY_W-1:0] pins;

    assign pins = {lower_byte_mask_n, upper_byte_mask_n, output_enable_n,
                   write_enable_n, address_valid_n, chip_select_n, burst_clk};

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sy1_reg <= {`PSBST_SY_W{1'b1}};
            sy2_reg <= {`PSBST_SY_W{1'b1}};
            sy3_reg <= {`PSBST_SY_W{1'b1}};
            addr1_reg <= ADDR_ZERO;
            addr2_reg <= ADDR_ZERO;
            din1_reg <= DATA_ZERO;
            din2_reg <= DATA_ZERO;
        end else begin
            sy1_reg <= pins;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
            addr1_reg <= addr;
            addr2_reg <= addr1_reg;
            din1_reg <= dq_in;
            din2_reg <= din1_reg;
        end
    end

    wire cs_low = ~sy2_reg[`PSBST_SY_CS];
    wire adv_low = ~sy2_reg[`PSBST_SY_ADV];
    wire oe_low = ~sy2_reg[`PSBST_SY_OE];
    wire bclk_rise = sy2_reg[`PSBST_SY_BCLK] & ~sy3_reg[`PSBST_SY_BCLK];
    wire cs_fall = ~sy2_reg[`PSBST_SY_CS] & sy3_reg[`PSBST_SY_CS];
    wire cs_rise = sy2_reg[`PSBST_SY_CS] & ~sy3_reg[`PSBST_SY_CS];
    wire adv_fall = ~sy2_reg[`PSBST_SY_ADV] & sy3_reg[`PSBST_SY_ADV];

    // ==========================================================
    // burst engine
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;
    reg [IDX_W-1:0] idx_reg;
    reg [IDX_W-1:0] idx_next;
    reg [ADDR_W-1:0] base_reg;
    reg [ADDR_W-1:0] base_next;
    reg is_write_reg;
    reg is_write_next;
    reg adv_used_reg;
    reg adv_used_next;
    reg present_now;
    reg write_now;
    wire [ADDR_W-1:0] word_addr;
    wire [DATA_W-1:0] rd_data;

    assign word_addr = base_reg + {{(ADDR_W-IDX_W){1'b0}}, idx_reg};

    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        base_next = base_reg;
        is_write_next = is_write_reg;
        adv_used_next = adv_used_reg & adv_low;
        present_now = 1'b0;
        write_now = 1'b0;
        if (!cs_low) begin
            // select high ends any burst at once, complete or not
            state_next = `PSBST_ST_IDLE;
            adv_used_next = 1'b0;
        end else if (bclk_rise && adv_low && !adv_used_reg) begin
            // only the first edge of a valid-low period opens a burst
            state_next = `PSBST_ST_LAT;
            cnt_next = CNT_ONE;
            idx_next = {IDX_W{1'b0}};
            base_next = addr2_reg;
            is_write_next = ~sy2_reg[`PSBST_SY_WE];
            adv_used_next = 1'b1;
        end else if (bclk_rise) begin
            // no burst clock edge, no progress: this is the suspend
            case (state_reg)
                `PSBST_ST_LAT: begin
                    cnt_next = cnt_reg + CNT_ONE;
                    if (cnt_reg + CNT_ONE == LAT_FULL) begin
                        state_next = `PSBST_ST_DATA;
                        present_now = ~is_write_reg;
                        write_now = is_write_reg;
                        idx_next = IDX_ONE;
                    end
                end
                `PSBST_ST_DATA: begin
                    if (idx_reg == IDX_LAST) begin
                        state_next = `PSBST_ST_DONE;
                    end else begin
                        present_now = ~is_write_reg;
                        write_now = is_write_reg;
                        idx_next = idx_reg + IDX_ONE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= `PSBST_ST_IDLE;
            cnt_reg <= {CNT_W{1'b0}};
            idx_reg <= {IDX_W{1'b0}};
            base_reg <= ADDR_ZERO;
            is_write_reg <= 1'b0;
            adv_used_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            base_reg <= base_next;
            is_write_reg <= is_write_next;
            adv_used_reg <= adv_used_next;
        end
    end

    // ==========================================================
    // storage; read word is prefetched from word_addr between edges
    psbst_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr_en(write_now),
        .wr_lane({~sy2_reg[`PSBST_SY_UB], ~sy2_reg[`PSBST_SY_LB]}),
        .wr_addr(word_addr),
        .wr_data(din2_reg),
        .rd_addr(word_addr),
        .rd_data_reg(rd_data)
    );

    // ==========================================================
    // pin drivers
    wire reading = ~is_write_reg &
                   ((state_reg == `PSBST_ST_DATA) | (state_reg == `PSBST_ST_DONE));

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dq_out_reg <= DATA_ZERO;
            dq_oe_reg <= 1'b0;
            wait_n_reg <= 1'b1;
            wait_oe_reg <= 1'b0;
        end else begin
            // held word stays put until the next presenting edge
            if (present_now) begin
                dq_out_reg <= rd_data;
            end
            dq_oe_reg <= reading & cs_low & oe_low & (state_next != `PSBST_ST_IDLE);
            if (cs_rise) begin
                wait_oe_reg <= 1'b0;
                wait_n_reg <= 1'b1;
            end else if (cs_fall || (cs_low && adv_fall)) begin
                wait_oe_reg <= 1'b1;
                wait_n_reg <= 1'b0;
            end else if (state_reg == `PSBST_ST_LAT && bclk_rise && cnt_next == LAT_READY) begin
                wait_n_reg <= 1'b1;
            end
        end
    end
endmodule

/* bench/psbst_props.sv */
/* checker of the burst engine pins: wait, data enable, held word.
   assumes it is bound to psbst_top and burst_clk phases last 4 cycles. */
module psbst_props #(
    parameter DATA_W = 16
) (
    input wire ref_clk,
    input wire nrst,
    input wire burst_clk,
    input wire chip_select_n,
    input wire address_valid_n,
    input wire output_enable_n,
    input wire [DATA_W-1:0] dq_out_reg,
    input wire dq_oe_reg,
    input wire wait_n_reg,
    input wire wait_oe_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // pins reach the outputs three cycles late, so windows reach 4
    sel_busy_a: assert property ($fell(chip_select_n) |-> ##[1:4] (wait_oe_reg && !wait_n_reg))
        else $error("wait not busy after select");
    adv_busy_a: assert property ($fell(address_valid_n) && !chip_select_n |-> ##[1:4] !wait_n_reg)
        else $error("wait not busy after valid");
    wait_rel_a: assert property ($rose(chip_select_n) |-> ##[1:4] !wait_oe_reg)
        else $error("wait not released");
    data_ready_a: assert property ($rose(dq_oe_reg) |-> wait_n_reg && wait_oe_reg)
        else $error("data before ready");
    ready_first_a: assert property ($rose(wait_n_reg) && wait_oe_reg |-> !dq_oe_reg)
        else $error("ready not ahead of data");
    sel_float_a: assert property (chip_select_n [*4] |-> !dq_oe_reg)
        else $error("data driven while deselected");
    oe_float_a: assert property (output_enable_n [*4] |-> !dq_oe_reg)
        else $error("data driven with enable high");
    hold_word_a: assert property ($stable(burst_clk) [*6] |-> $stable(dq_out_reg))
        else $error("word moved without clock");
endmodule

/* bench/psbst_host.sv */
/* host controller model driving the burst pins.
   assumes ref_clk at 125 MHz and a bench that sequences its tasks. */
module psbst_host (
    input wire ref_clk,
    output logic burst_clk,
    output logic chip_select_n,
    output logic address_valid_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic [7:0] addr,
    output logic [15:0] dq,
    output logic upper_byte_mask_n,
    output logic lower_byte_mask_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {burst_clk, chip_select_n, address_valid_n, write_enable_n, output_enable_n} = 5'h0F;
        addr = 8'h00;
        dq = 16'h0000;
        {upper_byte_mask_n, lower_byte_mask_n} = 2'h0;
    end
    // ==========================================================
    // pin sequencing
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // four cycles a phase, above the three the engine needs per level
    task automatic clk_edge();
        @(posedge ref_clk);
        burst_clk <= 1'b1;
        tick(4);
        burst_clk <= 1'b0;
        tick(3);
    endtask
    task automatic start_burst(input logic [7:0] a, input logic wr);
        @(posedge ref_clk);
        {chip_select_n, address_valid_n} <= 2'h0;
        addr <= a;
        write_enable_n <= !wr;
        output_enable_n <= wr;
        dq <= ~dq; // lines flip so no stale word survives
        tick(4);
    endtask
    // 64 ns idle covers every stop and turnaround gap
    task automatic end_burst();
        @(posedge ref_clk);
        {chip_select_n, address_valid_n, write_enable_n, output_enable_n} <= 4'hF;
        tick(8);
    endtask
endmodule

/* bench/psbst_top_tb.sv */
/* self-checking bench of the burst engine: write, read, suspend, stop.
   assumes psbst_host.sv and psbst_props.sv are compiled first. */
module psbst_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    wire burst_clk, chip_select_n, address_valid_n, write_enable_n, output_enable_n;
    wire [7:0] addr;
    wire [15:0] dq, dq_out_reg;
    wire dq_oe_reg, wait_n_reg, wait_oe_reg;
    wire upper_byte_mask_n, lower_byte_mask_n;
    logic [15:0] exp_mem [256];
    localparam logic [15:0] hi = 16'h0001;
    localparam logic [15:0] lo = 16'h0000;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 ref_clk = ~ref_clk;
    psbst_host host (.ref_clk(ref_clk), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
        .address_valid_n(address_valid_n), .write_enable_n(write_enable_n),
        .output_enable_n(output_enable_n), .addr(addr), .dq(dq),
        .upper_byte_mask_n(upper_byte_mask_n), .lower_byte_mask_n(lower_byte_mask_n));
    psbst_top dut (.ref_clk(ref_clk), .nrst(nrst), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
        .address_valid_n(address_valid_n), .write_enable_n(write_enable_n),
        .output_enable_n(output_enable_n), .upper_byte_mask_n(upper_byte_mask_n),
        .lower_byte_mask_n(lower_byte_mask_n),
        .addr(addr), .dq_in(dq), .dq_out_reg(dq_out_reg), .dq_oe_reg(dq_oe_reg),
        .wait_n_reg(wait_n_reg), .wait_oe_reg(wait_oe_reg));
    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        comparisons++;
        if (seen !== want) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    // mask_n gates the byte lanes of word one only; lanes left out keep their old value
    task automatic run(input logic [7:0] a, input logic wr, input int last, input int hold,
                       input logic [15:0] base, input logic [1:0] mask_n);
        logic [15:0] w;
        logic [7:0] i;
        host.start_burst(a, wr);
        check(16'(wait_oe_reg & ~wait_n_reg), hi, "wait busy");
        for (int k = 1; k <= last; k++) begin
            if (wr && k >= 5) host.dq <= base + 16'(k - 5);
            if (k == 6) {host.upper_byte_mask_n, host.lower_byte_mask_n} <= mask_n;
            if (k == 7) {host.upper_byte_mask_n, host.lower_byte_mask_n} <= 2'h0;
            host.clk_edge();
            if (k == hold) host.address_valid_n <= 1'b1;
            check(16'(wait_n_reg), 16'(k >= 4), "wait level");
            i = a + 8'(k - 5);
            w = base + 16'(k - 5);
            if (k == 6 && mask_n[1]) w[15:8] = exp_mem[i][15:8];
            if (k == 6 && mask_n[0]) w[7:0] = exp_mem[i][7:0];
            if (k >= 5 && wr) exp_mem[i] = w;
            if (k >= 5 && !wr) check(dq_out_reg, exp_mem[i], "read word");
            if (k >= 5) check(16'(dq_oe_reg), 16'(!wr), "data enable");
        end
        {host.upper_byte_mask_n, host.lower_byte_mask_n} <= 2'h0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_write();
        run(8'h10, 1'b1, 8, 1, 16'hA000, 2'h0);
        host.end_burst();
        check(16'(wait_oe_reg), lo, "wait release");
        $display("test write done");
    endtask
    task automatic t_read();
        run(8'h10, 1'b0, 8, 2, lo, 2'h0);
        host.end_burst();
        check(16'(wait_oe_reg | dq_oe_reg), lo, "release");
        $display("test read done");
    endtask
    task automatic t_suspend();
        run(8'h10, 1'b0, 6, 1, lo, 2'h0);
        host.tick(20);
        check(dq_out_reg, exp_mem[8'h11], "held word");
        host.output_enable_n <= 1'b1;
        host.tick(6);
        check(16'(dq_oe_reg), lo, "float");
        host.output_enable_n <= 1'b0;
        host.tick(6);
        check(16'(dq_oe_reg), hi, "redrive");
        host.clk_edge();
        check(dq_out_reg, exp_mem[8'h12], "resumed word");
        host.end_burst();
        $display("test suspend done");
    endtask
    // a write cut after two words must leave the last two untouched;
    // word one has its upper lane masked so it keeps its old upper byte
    task automatic t_stop();
        run(8'h10, 1'b1, 6, 1, 16'hB000, 2'h2);
        host.end_burst();
        run(8'h10, 1'b0, 8, 1, lo, 2'h0);
        host.end_burst();
        $display("test stop done");
    endtask
    // select stays low between bursts, so only a fresh valid pulse starts the read
    task automatic t_chain();
        run(8'h10, 1'b1, 8, 1, 16'hC0C0, 2'h1);
        run(8'h10, 1'b0, 8, 1, lo, 2'h0);
        host.end_burst();
        $display("test chain done");
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        host.tick(3);
        t_write();
        t_read();
        t_suspend();
        t_stop();
        t_chain();
        results();
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end
endmodule
bind psbst_top psbst_props #(.DATA_W(DATA_W)) chk (.ref_clk(ref_clk), .nrst(nrst), .burst_clk(burst_clk),
    .chip_select_n(chip_select_n), .address_valid_n(address_valid_n), .output_enable_n(output_enable_n),
    .dq_out_reg(dq_out_reg), .dq_oe_reg(dq_oe_reg), .wait_n_reg(wait_n_reg), .wait_oe_reg(wait_oe_reg));
